// file: src/internal_clock_enable.sv
// Internal clock enable: oscillator quartered, or passed at full rate
`timescale 1ns/1ps
`default_nettype none
module internal_clock_enable
  import rst_clk_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Oscillator tick and configuration
  input wire logic osc_tick,
  input wire logic doubler_active,
  // Internal clock enable
  output logic cpu_tick
);

  logic [1:0] phase;
  logic [1:0] next_phase;
  logic next_cpu_tick;

  // The CPU tick is the internal clock after a fixed halving. Doubled,
  // that is the oscillator rate; halved instead, a quarter of it, so
  // the two settings keep their factor of four
  always_comb begin
    next_phase = phase;
    next_cpu_tick = 1'b0;
    if (osc_tick) begin
      if (doubler_active) begin
        next_cpu_tick = 1'b1;
      end else begin
        next_phase = phase + 2'h1;
        next_cpu_tick = (phase == 2'h3);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase <= 2'h0;
      cpu_tick <= 1'b0;
    end else begin
      phase <= next_phase;
      cpu_tick <= next_cpu_tick;
    end
  end

endmodule
`default_nettype wire

// file: src/reset_and_clock_sequencer.sv
// Reset sequencer with open-drain reset pin and clock source selection
`timescale 1ns/1ps
`default_nettype none
module reset_and_clock_sequencer
  import rst_clk_pkg::*;
#(
  parameter int SHORT_DELAY = SHORT_DELAY_CYCLES,
  parameter int LONG_DELAY = LONG_DELAY_CYCLES,
  parameter int IN_PULSE = MIN_INPUT_PULSE_CYCLES,
  parameter int OUT_LOW = MIN_OUTPUT_LOW_CYCLES
)(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Option setting
  input wire option_t option,
  // Oscillator ticks, one per source, and the doubler range flag
  input wire logic ext_clk_tick,
  input wire logic [3:0] resonator_tick,
  input wire logic rc_tick,
  input wire logic doubler_in_range,
  // Internal reset sources
  input wire logic low_supply_detector,
  input wire logic watchdog_reset,
  // Reset pin, open drain
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // Vector fetch bus
  input wire logic [7:0] fetch_data,
  output logic fetch_req,
  output logic [15:0] fetch_addr,
  // Sequencer results
  output logic cpu_reset,
  output logic [15:0] reset_vector,
  output logic vector_valid,
  output logic [3:0] resonator_run,
  output logic doubler_active,
  output logic cpu_tick,
  output logic config_error
);

  localparam int CW = $clog2(LONG_DELAY + 1);
  localparam int PW = $clog2(OUT_LOW + IN_PULSE + 1);

  initial begin
    if (SHORT_DELAY < 1 || LONG_DELAY < SHORT_DELAY) begin
      $error("Delay counts out of range");
    end
    if (IN_PULSE < 1 || OUT_LOW < 1) begin
      $error("Pin timing counts out of range");
    end
  end

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_DELAY,
    ST_FETCH_HI,
    ST_FETCH_LO,
    ST_RUN
  } seq_state_t;

  seq_state_t state;
  seq_state_t next_state;
  logic [CW-1:0] delay_cnt;
  logic [CW-1:0] next_delay_cnt;
  logic [PW-1:0] pin_low_cnt;
  logic [PW-1:0] next_pin_low_cnt;
  logic [PW-1:0] stretch_cnt;
  logic [PW-1:0] next_stretch_cnt;
  logic [15:0] next_reset_vector;
  logic next_vector_valid;
  logic next_reset_pin_out;
  logic next_reset_pin_oe;
  logic next_fetch_req;
  logic [15:0] next_fetch_addr;
  logic next_cpu_reset;
  logic [3:0] next_resonator_run;
  logic next_doubler_active;
  logic next_config_error;
  logic osc_tick;
  logic ext_seen;
  logic pin_low;
  logic any_source;
  logic [CW-1:0] delay_end;

  // Source selection: one tick stream feeds the internal clock
  always_comb begin
    unique case (option.source)
      SRC_EXTERNAL: osc_tick = ext_clk_tick;
      SRC_RES0: osc_tick = resonator_tick[0];
      SRC_RES1: osc_tick = resonator_tick[1];
      SRC_RES2: osc_tick = resonator_tick[2];
      SRC_RES3: osc_tick = resonator_tick[3];
      SRC_INTERNAL_RC: osc_tick = rc_tick;
      default: osc_tick = 1'b0;
    endcase
  end

  internal_clock_enable u_clk_en (
    .clk(clk),
    .sys_rst(sys_rst),
    .osc_tick(osc_tick),
    .doubler_active(doubler_active),
    .cpu_tick(cpu_tick)
  );

  // The pin is sampled at clk, which stands for the always-running
  // detection path; it does not depend on the CPU tick
  assign pin_low = ~reset_pin_in;
  // A low we are driving ourselves is not an external request
  assign ext_seen = pin_low && !reset_pin_oe &&
                    (pin_low_cnt >= PW'(IN_PULSE - 1));
  assign any_source = ext_seen || low_supply_detector ||
                      watchdog_reset;
  assign delay_end = option.long_delay ? CW'(LONG_DELAY - 1) :
                     CW'(SHORT_DELAY - 1);

  // Pin watch: width of an external low and the stretch that follows
  always_comb begin
    next_pin_low_cnt = pin_low_cnt;
    next_stretch_cnt = stretch_cnt;

    // External low width measured only while the line is not ours
    if (pin_low && !reset_pin_oe) begin
      if (pin_low_cnt != '1) begin
        next_pin_low_cnt = pin_low_cnt + 1'b1;
      end
    end else begin
      next_pin_low_cnt = '0;
    end

    // Stretch: keep the pin low for the rest of the minimum low time,
    // so a pulse already longer than that gets nothing added
    if (ext_seen) begin
      if (pin_low_cnt + 1'b1 < PW'(OUT_LOW)) begin
        next_stretch_cnt = PW'(OUT_LOW) - pin_low_cnt - 1'b1;
      end else begin
        next_stretch_cnt = '0;
      end
    end else if (stretch_cnt != '0) begin
      next_stretch_cnt = stretch_cnt - 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    next_delay_cnt = delay_cnt;
    next_reset_vector = reset_vector;
    next_vector_valid = vector_valid;
    next_fetch_req = 1'b0;
    next_fetch_addr = fetch_addr;
    next_cpu_reset = cpu_reset;

    unique case (state)
      ST_ACTIVE: begin
        next_cpu_reset = 1'b1;
        next_vector_valid = 1'b0;
        next_delay_cnt = '0;
        if (!any_source && next_stretch_cnt == '0) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (cpu_tick) begin
          next_delay_cnt = delay_cnt + 1'b1;
        end
        if (cpu_tick && delay_cnt == delay_end) begin
          next_state = ST_FETCH_HI;
          next_fetch_req = 1'b1;
          next_fetch_addr = RESET_VECTOR_LO;
        end
      end
      ST_FETCH_HI: begin
        // Fetch spans two CPU ticks, high byte first
        if (cpu_tick) begin
          next_reset_vector[15:8] = fetch_data;
          next_state = ST_FETCH_LO;
          next_fetch_req = 1'b1;
          next_fetch_addr = RESET_VECTOR_HI;
        end else begin
          next_fetch_req = 1'b1;
        end
      end
      ST_FETCH_LO: begin
        if (cpu_tick) begin
          next_reset_vector[7:0] = fetch_data;
          next_vector_valid = 1'b1;
          next_cpu_reset = 1'b0;
          next_state = ST_RUN;
        end else begin
          next_fetch_req = 1'b1;
        end
      end
      ST_RUN: begin
      end
    endcase

    // Any active source restarts the whole sequence and its counter
    if (any_source) begin
      next_state = ST_ACTIVE;
      next_delay_cnt = '0;
      next_cpu_reset = 1'b1;
      next_vector_valid = 1'b0;
      next_fetch_req = 1'b0;
    end
  end

  // Pin drive: internal sources, stretch and the delay phase pull low
  always_comb begin
    next_reset_pin_out = 1'b0;
    next_reset_pin_oe = low_supply_detector || watchdog_reset ||
                        (next_stretch_cnt != '0) ||
                        next_state == ST_DELAY;
  end

  // Clock configuration; the doubler is refused for the RC source
  // and outside its input range
  always_comb begin
    next_doubler_active = option.doubler_en && doubler_in_range &&
                          option.source != SRC_INTERNAL_RC;
    next_config_error = option.doubler_en &&
                        option.source == SRC_INTERNAL_RC;
    next_resonator_run = '0;
    unique case (option.source)
      SRC_RES0: next_resonator_run = 4'h1;
      SRC_RES1: next_resonator_run = 4'h2;
      SRC_RES2: next_resonator_run = 4'h4;
      SRC_RES3: next_resonator_run = 4'h8;
      default: next_resonator_run = 4'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_low_cnt <= '0;
      stretch_cnt <= '0;
    end else begin
      pin_low_cnt <= next_pin_low_cnt;
      stretch_cnt <= next_stretch_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_ACTIVE;
      delay_cnt <= '0;
      reset_vector <= 16'h0000;
      vector_valid <= 1'b0;
      fetch_req <= 1'b0;
      fetch_addr <= 16'h0000;
      cpu_reset <= 1'b1;
    end else begin
      state <= next_state;
      delay_cnt <= next_delay_cnt;
      reset_vector <= next_reset_vector;
      vector_valid <= next_vector_valid;
      fetch_req <= next_fetch_req;
      fetch_addr <= next_fetch_addr;
      cpu_reset <= next_cpu_reset;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
    end else begin
      reset_pin_out <= next_reset_pin_out;
      reset_pin_oe <= next_reset_pin_oe;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resonator_run <= 4'h0;
      doubler_active <= 1'b0;
      config_error <= 1'b0;
    end else begin
      resonator_run <= next_resonator_run;
      doubler_active <= next_doubler_active;
      config_error <= next_config_error;
    end
  end

endmodule
`default_nettype wire

// file: src/rst_clk_pkg.sv
// Shared constants and carriers for the reset and clock sequencer
package rst_clk_pkg;

  // Oscillator source selection held in the option setting
  typedef enum logic [2:0] {
    SRC_EXTERNAL = 3'h0,
    SRC_RES0 = 3'h1,
    SRC_RES1 = 3'h2,
    SRC_RES2 = 3'h3,
    SRC_RES3 = 3'h4,
    SRC_INTERNAL_RC = 3'h5
  } osc_source_t;

  // Nonvolatile option setting as seen by this block
  typedef struct packed {
    osc_source_t source;
    logic doubler_en;
    logic long_delay;
  } option_t;

  // Reset source requests
  typedef struct packed {
    logic ext_pin;
    logic low_supply;
    logic watchdog;
  } rst_sources_t;

  // Reset vector location
  localparam logic [15:0] RESET_VECTOR_LO = 16'hFFFE;
  localparam logic [15:0] RESET_VECTOR_HI = 16'hFFFF;

  // Delay phase and fetch lengths in CPU clock cycles
  localparam int SHORT_DELAY_CYCLES = 256;
  localparam int LONG_DELAY_CYCLES = 4096;
  localparam int FETCH_CYCLES = 2;

  // Clock and pin timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MIN_INPUT_PULSE_NS = 40;
  localparam int MIN_OUTPUT_LOW_NS = 160;
  localparam int MIN_INPUT_PULSE_CYCLES =
    (MIN_INPUT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_OUTPUT_LOW_CYCLES =
    (MIN_OUTPUT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Doubler input range in kHz
  localparam int DOUBLER_MIN_KHZ = 2000;
  localparam int DOUBLER_MAX_KHZ = 4000;

endpackage

// file: tb/ext_reset_model.sv
// Board-side circuit that pulls the reset line low for a set time
`timescale 1ns/1ps
`default_nettype none
module ext_reset_model (
  // Clock
  input wire logic clk,
  // Pulse request
  input wire logic start,
  input wire logic [7:0] len,
  // Pull-down of the reset line
  output var logic pull_low
);
  logic [7:0] left = 8'h00;
  // A pulse under the minimum width may go unseen
  always @(posedge clk) begin
    if (start) left <= len;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  assign pull_low = (left != 8'h00);
endmodule
`default_nettype wire

// file: tb/reset_and_clock_sequencer_bench.sv
// Self-checking bench for the reset and clock sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_and_clock_sequencer_bench;
  import rst_clk_pkg::*;
  logic clk = 0, sys_rst = 1, ext_start = 0, osc = 0, wdg = 0, lsd = 0;
  logic in_rng = 1, vv_q = 0, pull_low, oe, fq, cres, vv, ctick, dact, cerr;
  logic [7:0] len = 8'h00, vhi = 8'h00, vlo = 8'h00;
  logic [1:0] tc = 2'h0;
  logic [3:0] rrun;
  logic [15:0] faddr, vec;
  logic [15:0] q[$];
  option_t opt = '{SRC_EXTERNAL, 1'b0, 1'b0};
  integer seed = 32'hC39665C1;
  int n_fail = 0, compares = 0, nf = 0, ns, nl, nr;
  // Short delay counts keep the run brief
  reset_and_clock_sequencer #(.SHORT_DELAY(4), .LONG_DELAY(8)) uut (
    .clk, .sys_rst, .option(opt), .ext_clk_tick(osc),
    .resonator_tick({4{osc}}), .rc_tick(osc), .doubler_in_range(in_rng),
    .low_supply_detector(lsd), .watchdog_reset(wdg),
    .reset_pin_in(!(oe || pull_low)), .reset_pin_out(), .reset_pin_oe(oe),
    .fetch_data(faddr == RESET_VECTOR_LO ? vhi : vlo), .fetch_req(fq),
    .fetch_addr(faddr), .cpu_reset(cres), .reset_vector(vec),
    .vector_valid(vv), .resonator_run(rrun), .doubler_active(dact),
    .cpu_tick(ctick), .config_error(cerr));
  ext_reset_model board (.clk, .start(ext_start), .len, .pull_low);
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    #1;
    tc = tc + 2'h1;
    osc = (tc == 2'h0);
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tk;
    @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    if (fq && ctick) nf = nf + 1;
    if (!sys_rst && vv && !vv_q) begin
      chk("vector", q.pop_front(), vec);
      chk("fetch_ticks", 16'h2, 16'(nf));
      nf = 0;
    end
    vv_q <= vv;
  end
  task automatic run_seq(input int how, output int n);
    vhi = 8'($random(seed));
    vlo = 8'($random(seed));
    q.push_back({vhi, vlo});
    n = 0;
    if (how == 0 || how == 3) wdg = 1;
    if (how == 1) lsd = 1;
    if (how == 2) len = 8'h08;
    if (how == 4) len = 8'hC8;
    ext_start = (how == 2 || how == 4);
    if (how == 9) sys_rst = 0;
    tk;
    ext_start = 0;
    repeat ((how == 2 || how == 4) ? 9 : 2) tk;
    wdg = 0;
    lsd = 0;
    for (int i = 0; i < 2000 && cres; i++) begin
      if (how == 3 && i == 20) lsd = 1;
      if (how == 3 && i == 22) begin
        lsd = 0;
        n = 0;
      end
      if (i == 5 && opt.source == SRC_RES3) chk("run_rst", 16'h8, 16'(rrun));
      tk;
      if (ctick) n++;
    end
    chk("released", 16'h0, 16'(cres));
    if (how == 4) chk("held", 16'h0, 16'(pull_low));
  endtask
  task automatic rate(input int e);
    int c;
    c = 0;
    repeat (32) begin
      tk;
      if (ctick) c++;
    end
    chk("ticks", 16'(e), 16'(c));
  endtask
  task print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    run_seq(9, ns);
    run_seq(0, ns);
    opt.long_delay = 1;
    opt.source = SRC_RES3;
    run_seq(0, nl);
    run_seq(3, nr);
    chk("delay_diff", 16'h4, 16'(nl - ns));
    chk("restart", 16'(nl), 16'(nr));
    run_seq(1, nr);
    run_seq(2, ns);
    run_seq(4, nr);
    len = 8'h02;
    ext_start = 1;
    tk;
    ext_start = 0;
    repeat (30) tk;
    chk("short_pulse", 16'h0, 16'(cres));
    for (int s = 0; s < 6; s++) begin
      opt.source = osc_source_t'(s);
      tk;
      tk;
      chk("run", (s inside {[1:4]}) ? 16'(1 << (s - 1)) : 16'h0, 16'(rrun));
    end
    opt.doubler_en = 1;
    tk;
    tk;
    chk("cfg_err", 16'h1, 16'(cerr));
    chk("rc_dbl", 16'h0, 16'(dact));
    opt.source = SRC_EXTERNAL;
    tk;
    tk;
    chk("dbl_on", 16'h1, 16'(dact));
    rate(8);
    in_rng = 0;
    tk;
    tk;
    chk("dbl_range", 16'h0, 16'(dact));
    rate(2);
    print_verdict;
  end
  // Whole run needs well under two thousand cycles
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
endmodule
`default_nettype wire

// file: tb/rst_seq_sva.sv
// Checker for reset pin, vector fetch and clock setup outputs
`timescale 1ns/1ps
`default_nettype none
module rst_seq_sva
  import rst_clk_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire option_t option,
  input wire logic doubler_in_range,
  input wire logic low_supply_detector,
  input wire logic watchdog_reset,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic cpu_reset,
  input wire logic vector_valid,
  input wire logic [3:0] resonator_run,
  input wire logic doubler_active,
  input wire logic config_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence ext_low_seen;
    (!reset_pin_in && !reset_pin_oe) [*5];
  endsequence
  sequence fetch_lo_step;
    $rose(fetch_req) && fetch_addr == RESET_VECTOR_LO;
  endsequence
  a_open_drain: assert property (reset_pin_out == 1'b0)
    else $error("reset pin driven high");
  a_internal_src: assert property ((watchdog_reset || low_supply_detector)
    |=> reset_pin_oe && cpu_reset) else $error("source ignored");
  a_ext_stretch: assert property (ext_low_seen |=> reset_pin_oe [*8])
    else $error("external pulse not stretched");
  a_fetch_start: assert property (fetch_lo_step |-> $past(reset_pin_oe))
    else $error("pin released before fetch");
  a_fetch_first: assert property ($rose(fetch_req) |-> fetch_lo_step)
    else $error("fetch does not start at low vector byte");
  a_vector_done: assert property ($rose(vector_valid) |->
    $past(fetch_addr) == RESET_VECTOR_HI && !cpu_reset && !fetch_req)
    else $error("vector done out of order");
  a_sources_clear: assert property ($fell(cpu_reset) |->
    !$past(watchdog_reset) && !$past(low_supply_detector))
    else $error("reset ended with a source active");
  a_rc_refused: assert property ((option.doubler_en &&
    option.source == SRC_INTERNAL_RC) |=> config_error && !doubler_active)
    else $error("doubler allowed with RC source");
  a_doubler_gate: assert property (doubler_active |->
    !config_error && $past(doubler_in_range))
    else $error("doubler active out of range");
  a_res_select: assert property (option.source == SRC_RES2 |=>
    resonator_run == 4'h4) else $error("wrong resonator");
  a_ext_no_res: assert property (option.source == SRC_EXTERNAL |=>
    resonator_run == 4'h0) else $error("resonator on for ext");
endmodule
bind reset_and_clock_sequencer rst_seq_sva chk (.clk, .sys_rst, .option,
  .doubler_in_range, .low_supply_detector, .watchdog_reset, .reset_pin_in,
  .reset_pin_out, .reset_pin_oe, .fetch_req, .fetch_addr, .cpu_reset,
  .vector_valid, .resonator_run, .doubler_active, .config_error);
`default_nettype wire
